// *** hdl/pcr_dev.sv ***
//
// Overview of operation
// - Copy/read commands accept 8 or 16 clocks
// - Save copies wiper into storage
// - Storage never written without a command
// - Host saves before removing power
// - Store holds busy for defined interval
// - Restore loads wiper from storage
// - Restore runs automatically after power-up
// - Data line is input while select low
// - Read storage drives stored value, msb first
// - Read wiper drives wiper value, msb first
// - Wiper read leaves wiper unchanged
// - Output starts at second clock after select
// - Host keeps select high during readback
// - Select fall releases data line
// - Command byte first; fixed command codes
// - Execute only at select rise
// - Bit count not 8 or 16: nothing
// - Storage write busy at most 20 ms
//
`timescale 1ns/1ns
module pcr_dev #(
   parameter int BUSY_CYC = pcr_pkg::BUSY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   pcr_if.dev link,
   output logic [7:0] wiper_pos,
   output logic [7:0] stored_pos,
   output logic nv_busy
);
   import pcr_pkg::*;

   localparam logic [20:0] BUSY_LAST = 21'(BUSY_CYC - 1);

   logic [2:0] sclk_sync_ff;
   logic [2:0] sel_sync_ff;
   logic [1:0] sdio_sync_ff;
   logic sclk_rise;
   logic sel_rise;
   logic sel_fall;
   logic sel_high;

   logic [15:0] shift_ff;
   logic [4:0] bit_cnt_ff;
   logic frame_short;
   logic frame_long;
   logic exec;
   logic [7:0] cmd_code;
   logic [7:0] cmd_data;
   logic do_save;
   logic do_restore;
   logic do_read_nv;
   logic do_read_wiper;
   logic do_write_wiper;
   logic do_write_nv;

   logic [7:0] wiper_ff;
   logic por_pend_ff;
   logic [7:0] nv_ff = NV_FACTORY;
   logic [7:0] nv_pend_ff;
   logic busy_ff;
   logic [20:0] busy_cnt_ff;
   logic busy_done;

   logic rd_active_ff;
   logic [7:0] out_sr_ff;
   logic [3:0] rd_edge_ff;
   logic [3:0] nxt_rd_edge;
   logic sdo_ff;
   logic oe_n_ff;

   // ------------------------------------------------------------
   // Input synchronisers and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclk_sync_ff <= 3'h0;
         sel_sync_ff <= 3'h7;
         sdio_sync_ff <= 2'h0;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], link.sclk};
         sel_sync_ff <= {sel_sync_ff[1:0], link.select_low};
         sdio_sync_ff <= {sdio_sync_ff[0], link.sdio};
      end
   end

   assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
   assign sel_rise = sel_sync_ff[1] & ~sel_sync_ff[2];
   assign sel_fall = ~sel_sync_ff[1] & sel_sync_ff[2];
   assign sel_high = sel_sync_ff[1];

   // ------------------------------------------------------------
   // Serial input shifter
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         shift_ff <= 16'h0000;
         bit_cnt_ff <= 5'h00;
      end else if (sel_fall) begin
         bit_cnt_ff <= 5'h00;
      end else if (!sel_high && sclk_rise) begin
         // Input taken only while select low
         shift_ff <= {shift_ff[14:0], sdio_sync_ff[1]};
         if (bit_cnt_ff != FRAME_CNT_MAX) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Command decode at select rise
   // ------------------------------------------------------------
   assign frame_short = (bit_cnt_ff == FRAME_SHORT);
   assign frame_long = (bit_cnt_ff == FRAME_LONG);
   assign exec = sel_rise && (frame_short || frame_long);
   assign cmd_code = frame_long ? shift_ff[LONG_CMD_MSB:LONG_CMD_LSB] :
                     shift_ff[COMMAND_BIT_MSB:COMMAND_BIT_LSB];
   assign cmd_data = shift_ff[COMMAND_BIT_MSB:COMMAND_BIT_LSB];
   assign do_save = exec && (cmd_code == CMD_SAVE);
   assign do_restore = exec && (cmd_code == CMD_RESTORE);
   assign do_read_nv = exec && (cmd_code == CMD_READ_NV);
   assign do_read_wiper = exec && (cmd_code == CMD_READ_WIPER);
   assign do_write_wiper = exec && frame_long && (cmd_code == CMD_WRITE_WIPER);
   assign do_write_nv = exec && frame_long && (cmd_code == CMD_WRITE_NV);

   // ------------------------------------------------------------
   // Wiper register and power-up restore
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wiper_ff <= WIPER_RESET;
         por_pend_ff <= 1'b1;
      end else begin
         por_pend_ff <= 1'b0;
         if (por_pend_ff) begin
            wiper_ff <= nv_ff;
         end else if (do_restore) begin
            wiper_ff <= nv_ff;
         end else if (do_write_wiper) begin
            wiper_ff <= cmd_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Nonvolatile store and busy interval
   // ------------------------------------------------------------
   assign busy_done = busy_ff && (busy_cnt_ff == BUSY_LAST);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         busy_ff <= 1'b0;
         busy_cnt_ff <= 21'h000000;
         nv_pend_ff <= 8'h00;
      end else if (busy_ff) begin
         busy_cnt_ff <= busy_cnt_ff + 21'h000001;
         if (busy_done) begin
            busy_ff <= 1'b0;
         end
      end else if (do_save) begin
         nv_pend_ff <= wiper_ff;
         busy_ff <= 1'b1;
         busy_cnt_ff <= 21'h000000;
      end else if (do_write_nv) begin
         nv_pend_ff <= cmd_data;
         busy_ff <= 1'b1;
         busy_cnt_ff <= 21'h000000;
      end
   end

   // Storage keeps its value across reset; changed only by a command
   always_ff @(posedge ref_clk) begin
      if (busy_done) begin
         nv_ff <= nv_pend_ff;
      end
   end

   // ------------------------------------------------------------
   // Readback driver
   // ------------------------------------------------------------
   assign nxt_rd_edge = (rd_edge_ff == RD_EDGE_MAX) ? rd_edge_ff : rd_edge_ff + 4'h1;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_active_ff <= 1'b0;
         out_sr_ff <= 8'h00;
         rd_edge_ff <= 4'h0;
         sdo_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else if (do_read_nv || do_read_wiper) begin
         // Copy taken, source register untouched
         out_sr_ff <= do_read_nv ? nv_ff : wiper_ff;
         rd_active_ff <= 1'b1;
         rd_edge_ff <= 4'h0;
         sdo_ff <= 1'b0;
         oe_n_ff <= 1'b0;
      end else if (sel_fall) begin
         rd_active_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         sdo_ff <= 1'b0;
      end else if (rd_active_ff && sel_high && sclk_rise) begin
         rd_edge_ff <= nxt_rd_edge;
         if (nxt_rd_edge >= RD_FIRST_EDGE && nxt_rd_edge <= RD_LAST_EDGE) begin
            sdo_ff <= out_sr_ff[7];
            out_sr_ff <= {out_sr_ff[6:0], out_sr_ff[7]};
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.dev_sdio_o = sdo_ff;
   assign link.dev_sdio_oe_n = oe_n_ff;
   assign wiper_pos = wiper_ff;
   assign stored_pos = nv_ff;
   assign nv_busy = busy_ff;
endmodule

// *** inc/pcr_pkg.sv ***
package pcr_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 100;
   localparam int T_BUSY_MS = 20;
   localparam int BUSY_CYCLES = T_BUSY_MS * 1000 * CLK_FREQ_MHZ;
   localparam int T_SCLK_HALF_NS = 120;
   localparam int SCLK_HALF_CYCLES = (T_SCLK_HALF_NS * CLK_FREQ_MHZ + 999) / 1000;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_WIPER = 8'h00;
   localparam logic [7:0] CMD_WRITE_NV = 8'h10;
   localparam logic [7:0] CMD_SAVE = 8'h20;
   localparam logic [7:0] CMD_RESTORE = 8'h30;
   localparam logic [7:0] CMD_READ_NV = 8'h28;
   localparam logic [7:0] CMD_READ_WIPER = 8'h68;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int COMMAND_BIT_MSB = 7;
   localparam int COMMAND_BIT_LSB = 0;
   localparam int LONG_CMD_MSB = 15;
   localparam int LONG_CMD_LSB = 8;
   localparam logic [4:0] FRAME_SHORT = 5'h08;
   localparam logic [4:0] FRAME_LONG = 5'h10;
   localparam logic [4:0] FRAME_CNT_MAX = 5'h11;

   // ------------------------------------------------------------
   // Readback edges and reset values
   // ------------------------------------------------------------
   localparam logic [3:0] RD_FIRST_EDGE = 4'h2;
   localparam logic [3:0] RD_LAST_EDGE = 4'h9;
   localparam logic [3:0] RD_EDGE_MAX = 4'hf;
   localparam logic [7:0] NV_FACTORY = 8'h80;
   localparam logic [7:0] WIPER_RESET = 8'h00;

endpackage

// *** inc/pcr_if.sv ***
`timescale 1ns/1ns
interface pcr_if;
   logic sclk;
   logic select_low;
   logic host_sdio_o;
   logic host_sdio_oe_n;
   logic dev_sdio_o;
   logic dev_sdio_oe_n;
   logic sdio;

   // ------------------------------------------------------------
   // Shared data line, pulled high when nobody drives
   // ------------------------------------------------------------
   assign sdio = !host_sdio_oe_n ? host_sdio_o : (!dev_sdio_oe_n ? dev_sdio_o : 1'b1);

   modport host (
      output sclk,
      output select_low,
      output host_sdio_o,
      output host_sdio_oe_n,
      input sdio
   );

   modport dev (
      input sclk,
      input select_low,
      input sdio,
      output dev_sdio_o,
      output dev_sdio_oe_n
   );
endinterface

// *** hdl/pcr_host.sv ***
`timescale 1ns/1ns
module pcr_host (
   input wire logic ref_clk,
   input wire logic reset,
   pcr_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_long,
   output logic resp_valid,
   output logic [7:0] resp_data
);
   import pcr_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE, H_LEAD, H_SHIFT, H_TAIL, H_RDCLK, H_RDEND, H_RDREL, H_GAP
   } pcr_host_state_e;

   localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);

   pcr_host_state_e state_ff;
   logic [3:0] div_ff;
   logic tick;
   logic [1:0] sdio_sync_ff;
   logic sclk_ff;
   logic sel_n_ff;
   logic sdo_ff;
   logic oe_n_ff;
   logic [15:0] sr_ff;
   logic [4:0] nbits_ff;
   logic [4:0] bit_cnt_ff;
   logic is_read_ff;
   logic [3:0] rcnt_ff;
   logic [7:0] rsr_ff;
   logic resp_valid_ff;

   // ------------------------------------------------------------
   // Serial clock divider
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         div_ff <= 4'h0;
      end else if (div_ff == HALF_LAST) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   assign tick = (div_ff == HALF_LAST);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sdio_sync_ff <= 2'h0;
      end else begin
         sdio_sync_ff <= {sdio_sync_ff[0], link.sdio};
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_ff <= H_IDLE;
         sclk_ff <= 1'b0;
         sel_n_ff <= 1'b1;
         sdo_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         sr_ff <= 16'h0000;
         nbits_ff <= 5'h00;
         bit_cnt_ff <= 5'h00;
         is_read_ff <= 1'b0;
         rcnt_ff <= 4'h0;
         rsr_ff <= 8'h00;
         resp_valid_ff <= 1'b0;
      end else begin
         resp_valid_ff <= 1'b0;
         case (state_ff)
            H_IDLE: begin
               if (cmd_valid) begin
                  // Command byte first, msb first
                  sr_ff <= cmd_long ? {cmd_code, cmd_data} : {cmd_code, 8'h00};
                  nbits_ff <= cmd_long ? FRAME_LONG : FRAME_SHORT;
                  is_read_ff <= (cmd_code == CMD_READ_NV) || (cmd_code == CMD_READ_WIPER);
                  sdo_ff <= cmd_code[COMMAND_BIT_MSB];
                  sel_n_ff <= 1'b0;
                  oe_n_ff <= 1'b0;
                  bit_cnt_ff <= 5'h00;
                  state_ff <= H_LEAD;
               end
            end
            H_LEAD: begin
               if (tick) begin
                  state_ff <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  if (!sclk_ff) begin
                     sclk_ff <= 1'b1;
                     bit_cnt_ff <= bit_cnt_ff + 5'h01;
                  end else begin
                     sclk_ff <= 1'b0;
                     if (bit_cnt_ff == nbits_ff) begin
                        state_ff <= H_TAIL;
                     end else begin
                        sr_ff <= {sr_ff[14:0], 1'b0};
                        sdo_ff <= sr_ff[14];
                     end
                  end
               end
            end
            H_TAIL: begin
               if (tick) begin
                  sel_n_ff <= 1'b1;
                  oe_n_ff <= 1'b1;
                  rcnt_ff <= 4'h0;
                  state_ff <= is_read_ff ? H_RDCLK : H_GAP;
               end
            end
            H_RDCLK: begin
               // Select stays high through the whole readback
               if (tick) begin
                  sclk_ff <= ~sclk_ff;
                  if (!sclk_ff) begin
                     rcnt_ff <= rcnt_ff + 4'h1;
                  end else begin
                     if (rcnt_ff >= RD_FIRST_EDGE) begin
                        rsr_ff <= {rsr_ff[6:0], sdio_sync_ff[1]};
                     end
                     if (rcnt_ff == RD_LAST_EDGE) begin
                        state_ff <= H_RDEND;
                     end
                  end
               end
            end
            H_RDEND: begin
               if (tick) begin
                  sel_n_ff <= 1'b0;
                  resp_valid_ff <= 1'b1;
                  state_ff <= H_RDREL;
               end
            end
            H_RDREL: begin
               if (tick) begin
                  sel_n_ff <= 1'b1;
                  state_ff <= H_GAP;
               end
            end
            H_GAP: begin
               if (tick) begin
                  state_ff <= H_IDLE;
               end
            end
            default: begin
               state_ff <= H_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cmd_ready = (state_ff == H_IDLE);
   assign resp_valid = resp_valid_ff;
   assign resp_data = rsr_ff;
   assign link.sclk = sclk_ff;
   assign link.select_low = sel_n_ff;
   assign link.host_sdio_o = sdo_ff;
   assign link.host_sdio_oe_n = oe_n_ff;
endmodule

// *** tb/pcr_chk.sv ***
`timescale 1ns/1ns
module pcr_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic select_low,
   input wire logic host_sdio_o,
   input wire logic host_sdio_oe_n,
   input wire logic dev_sdio_o,
   input wire logic dev_sdio_oe_n,
   input wire logic sdio
);
   localparam int SETTLE = 6;
   logic sclk_ff;
   logic sclk_up;
   logic [4:0] bits_ff;
   logic [3:0] rises_ff;
   logic [3:0] since_ff;
   assign sclk_up = sclk && !sclk_ff;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // Wire counters
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclk_ff <= 1'b0;
         bits_ff <= 5'h00;
         rises_ff <= 4'h0;
      end else begin
         sclk_ff <= sclk;
         bits_ff <= select_low ? 5'h00 : bits_ff + {4'h0, sclk_up};
         rises_ff <= !select_low ? 4'h0 : rises_ff + {3'h0, sclk_up && rises_ff != 4'hf};
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         since_ff <= 4'hf;
      else
         since_ff <= sclk_up ? 4'h0 : since_ff + {3'h0, since_ff != 4'hf};
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_ONE_DRIVER:
      assert property (host_sdio_oe_n || dev_sdio_oe_n) else $error("data line driven twice");
   AST_DEV_INPUT_SEL_LOW:
      assert property ((!select_low) [*5] |-> dev_sdio_oe_n) else $error("device drives in frame");
   AST_RELEASE_ON_FALL:
      assert property ($fell(select_low) |-> ##[1:SETTLE] dev_sdio_oe_n)
      else $error("data line not released");
   AST_HOST_QUIET:
      assert property (select_low |-> host_sdio_oe_n) else $error("host drives after frame");
   AST_DRIVE_AFTER_RISE:
      assert property ($fell(dev_sdio_oe_n) |-> select_low && $past(select_low, 2))
      else $error("device drives before select rise");
   AST_ZERO_BEFORE_DATA:
      assert property (select_low && !dev_sdio_oe_n && rises_ff < 4'h2 |-> !dev_sdio_o)
      else $error("readback starts early");
   AST_BIT_ON_CLOCK:
      assert property (select_low && !dev_sdio_oe_n && !$past(dev_sdio_oe_n)
         && $changed(dev_sdio_o) |-> since_ff <= SETTLE) else $error("bit moves off clock");
   AST_FRAME_BITS:
      assert property ($rose(select_low) |-> bits_ff inside {5'h00, 5'h08, 5'h10})
      else $error("bad frame length");
   AST_SEL_HELD:
      assert property (select_low && !dev_sdio_oe_n && rises_ff < 4'h9 |=> select_low)
      else $error("select dropped in readback");
   cover property ($fell(dev_sdio_oe_n));
   cover property ($rose(select_low) && bits_ff == 5'h10);
   cover property ($rose(select_low) && bits_ff == 5'h08);
   cover property (!dev_sdio_oe_n && select_low && sdio);
   cover property (!host_sdio_oe_n && !select_low && host_sdio_o);
endmodule

// *** tb/test_pot_copy_and_readback_commands.sv ***
`timescale 1ns/1ns
module test_pot_copy_and_readback_commands;
   import pcr_pkg::*;
   localparam int BUSY = 50;
   logic ref_clk;
   logic reset;
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cmd_code;
   logic [7:0] cmd_data;
   logic cmd_long;
   logic resp_valid;
   logic [7:0] resp_data;
   logic [7:0] wiper_pos;
   logic [7:0] stored_pos;
   logic nv_busy;
   logic [7:0] wiper2;
   logic [7:0] rb_sh;
   logic seen_resp;
   int bits;
   time busy_rise;
   int busy_len;
   int miscompares;
   int n_compared;
   int bad[4] = '{7, 9, 15, 17};
   pcr_if link ();
   pcr_if link2 ();
   pcr_host pcr_host_i (.ref_clk(ref_clk), .reset(reset), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_long(cmd_long),
      .resp_valid(resp_valid), .resp_data(resp_data));
   pcr_dev #(.BUSY_CYC(BUSY)) pcr_dev_i (.ref_clk(ref_clk), .reset(reset), .link(link),
      .wiper_pos(wiper_pos), .stored_pos(stored_pos), .nv_busy(nv_busy));
   pcr_dev #(.BUSY_CYC(BUSY)) pcr_dev_2_i (.ref_clk(ref_clk), .reset(reset), .link(link2),
      .wiper_pos(wiper2), .stored_pos(), .nv_busy());
   pcr_chk pcr_chk_i (.ref_clk(ref_clk), .reset(reset), .sclk(link.sclk),
      .select_low(link.select_low), .host_sdio_o(link.host_sdio_o),
      .host_sdio_oe_n(link.host_sdio_oe_n), .dev_sdio_o(link.dev_sdio_o),
      .dev_sdio_oe_n(link.dev_sdio_oe_n), .sdio(link.sdio));
   // ------------------------------------------------------------
   // Clock, wire monitors, tasks
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(negedge link.sclk) if (link.select_low === 1'b1) rb_sh <= {rb_sh[6:0], link.sdio};
   always @(posedge link.sclk) if (link.select_low === 1'b0) bits++;
   always @(posedge nv_busy) busy_rise = $time;
   always @(negedge nv_busy) busy_len = int'(($time - busy_rise) / 10);
   always @(posedge link.select_low) begin
      check(8'(bits == 0 || bits == 8 || bits == 16), 8'h01);
      bits = 0;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] code, input logic [7:0] data, input logic lng);
      int n;
      n = 0;
      @(negedge ref_clk);
      cmd_code = code;
      cmd_data = data;
      cmd_long = lng;
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      seen_resp = 1'b0;
      while (cmd_ready !== 1'b1 && n < 2000) begin
         seen_resp = seen_resp | (resp_valid === 1'b1);
         n++;
         @(negedge ref_clk);
      end
      if (n == 2000) check(8'h00, 8'hff);
   endtask
   task automatic read_chk(input logic [7:0] code, input logic lng, input logic [7:0] exp);
      send(code, 8'hff, lng);
      check({7'h0, seen_resp}, 8'h01);
      check(resp_data, exp);
      check(rb_sh, exp);
   endtask
   task automatic busy_wait(input logic [7:0] old_nv, input logic [7:0] new_nv);
      int n;
      n = 0;
      while (nv_busy !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      check(stored_pos, old_nv);
      n = 0;
      while (nv_busy === 1'b1 && n < 1000) begin
         @(negedge ref_clk);
         n++;
      end
      check(8'(busy_len), 8'(BUSY));
      check(stored_pos, new_nv);
   endtask
   task automatic raw(input logic [15:0] word, input int n);
      @(negedge ref_clk);
      #2;
      link2.select_low = 1'b0;
      link2.host_sdio_oe_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         link2.host_sdio_o = word[15];
         word = word << 1;
         #62 link2.sclk = 1'b1;
         #63 link2.sclk = 1'b0;
      end
      #62 link2.select_low = 1'b1;
      link2.host_sdio_oe_n = 1'b1;
      link2.host_sdio_o = 1'b0;
      repeat (10) @(negedge ref_clk);
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      miscompares = 0;
      n_compared = 0;
      bits = 0;
      rb_sh = 8'h00;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_data = 8'h00;
      cmd_long = 1'b0;
      link2.sclk = 1'b0;
      link2.select_low = 1'b1;
      link2.host_sdio_o = 1'b0;
      link2.host_sdio_oe_n = 1'b1;
      for (int r = 0; r < 2; r++) begin
         reset = 1'b1;
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         reset = 1'b0;
         repeat (3) @(negedge ref_clk);
         check(wiper_pos, r == 0 ? NV_FACTORY : 8'h3c);
         check(stored_pos, r == 0 ? NV_FACTORY : 8'h3c);
         if (r == 0) begin
            send(CMD_WRITE_WIPER, 8'h5a, 1'b1);
            read_chk(CMD_READ_WIPER, 1'b0, 8'h5a);
            read_chk(CMD_READ_WIPER, 1'b1, 8'h5a);
            check(wiper_pos, 8'h5a);
            read_chk(CMD_READ_NV, 1'b0, NV_FACTORY);
            send(CMD_SAVE, 8'hff, 1'b0);
            busy_wait(NV_FACTORY, 8'h5a);
            read_chk(CMD_READ_NV, 1'b1, 8'h5a);
            send(CMD_WRITE_WIPER, 8'h33, 1'b1);
            send(CMD_RESTORE, 8'hff, 1'b1);
            check(wiper_pos, 8'h5a);
            send(CMD_WRITE_WIPER, 8'hc3, 1'b1);
            send(CMD_SAVE, 8'h00, 1'b1);
            busy_wait(8'h5a, 8'hc3);
            send(CMD_WRITE_NV, 8'h3c, 1'b1);
            busy_wait(8'hc3, 8'h3c);
            check(wiper_pos, 8'hc3);
            send(CMD_RESTORE, 8'h00, 1'b0);
            check(wiper_pos, 8'h3c);
         end
      end
      raw({CMD_WRITE_WIPER, 8'h11}, 16);
      check(wiper2, 8'h11);
      for (int i = 0; i < 4; i++) begin
         raw({CMD_RESTORE, 8'h00}, bad[i]);
         check(wiper2, 8'h11);
      end
      raw({CMD_RESTORE, 8'h00}, 8);
      check(wiper2, NV_FACTORY);
      end_of_test();
   end
   initial begin
      #1000000;
      miscompares++;
      end_of_test();
   end
endmodule
